// File: rivm_pkg.sv
// Purpose: Shared constants for the reset and interrupt vector map
// Assumes: Word-addressed program memory, 12-bit program counter
// Notes:   Vector numbers count from zero for the first interrupt source
package rivm_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W    = 12;
	localparam int unsigned NUM_IRQ   = 18;
	localparam int unsigned IDX_W     = 5;
	localparam int unsigned CTL_W     = 8;

	// ----------------------------------------------------------------
	// Addresses and fields
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] APP_RESET_ADDR  = 12'h000;
	localparam logic [ADDR_W-1:0] APP_TABLE_START = 12'h001;
	localparam logic [ADDR_W-1:0] VEC_STEP        = 12'h001;
	localparam logic [ADDR_W-1:0] BOOT_RESET_DFLT = 12'hC00; // Plain default, set by section size
	localparam int unsigned       VSEL_BIT        = 1;
	localparam logic [CTL_W-1:0]  CTL_RST         = 8'h00;
	localparam logic              FUSE_UNPROG     = 1'b1;
	localparam logic [IDX_W-1:0]  IDX_ZERO        = 5'h00;

	// ----------------------------------------------------------------
	// Request bit order, lowest vector first
	// ----------------------------------------------------------------
	localparam int unsigned IRQ_EXT0   = 0;   // 0x001
	localparam int unsigned IRQ_EXT1   = 1;   // 0x002
	localparam int unsigned IRQ_T2CMP  = 2;   // 0x003
	localparam int unsigned IRQ_T2OVF  = 3;
	localparam int unsigned IRQ_T1CAP  = 4;
	localparam int unsigned IRQ_T1CMPA = 5;
	localparam int unsigned IRQ_T1CMPB = 6;
	localparam int unsigned IRQ_T1OVF  = 7;
	localparam int unsigned IRQ_T0OVF  = 8;   // 0x009
	localparam int unsigned IRQ_SPI    = 9;   // 0x00A
	localparam int unsigned IRQ_URX    = 10;
	localparam int unsigned IRQ_UTXE   = 11;
	localparam int unsigned IRQ_UTX    = 12;
	localparam int unsigned IRQ_ADC    = 13;
	localparam int unsigned IRQ_EE     = 14;
	localparam int unsigned IRQ_ACMP   = 15;
	localparam int unsigned IRQ_TWI    = 16;
	localparam int unsigned IRQ_STORE  = 17;  // 0x012

	// ----------------------------------------------------------------
	// Dispatch states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		RIVM_ST_IDLE  = 3'b001,
		RIVM_ST_RESET = 3'b010,
		RIVM_ST_IRQ   = 3'b100
	} rivm_state_e;

endpackage

// File: rivm_prio_enc.sv
// Purpose: Lowest-index-first priority encoder over pending requests
// Assumes: Pure combinational, same clock domain as its user
// Notes:   Index zero wins; any_pending low means index is meaningless
`timescale 1ns/1ps
module rivm_prio_enc
	import rivm_pkg::*;
(
	input  wire logic [NUM_IRQ-1:0] req,
	output logic      [IDX_W-1:0]   idx,
	output logic                    any_pending
);

	// ----------------------------------------------------------------
	// Scan from the top so the lowest set bit is the last to win
	// ----------------------------------------------------------------
	always_comb begin
		idx         = IDX_ZERO;
		any_pending = 1'b0;
		for (int i = NUM_IRQ - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx         = IDX_W'(i);
				any_pending = 1'b1;
			end
		end
	end

endmodule // rivm_prio_enc

// File: rivm_vector_map.sv
// Purpose: Fetch address generator for reset and the eighteen interrupt vectors
// Assumes: Core takes vec_addr when vec_valid and vec_ready are both high
// Notes:   Requests are levels held by peripherals until the core acknowledges
`timescale 1ns/1ps
module rivm_vector_map
	import rivm_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                srst,
	input  wire logic                clk_en,
	input  wire logic                boot_reset_fuse,
	input  wire logic [ADDR_W-1:0]   boot_reset_addr,
	input  wire logic                irq_ctl_wr,
	input  wire logic [CTL_W-1:0]    irq_ctl_wdata,
	input  wire logic                external_request_0,
	input  wire logic                external_request_1,
	input  wire logic                timer2_compare_event,
	input  wire logic                timer2_overflow_event,
	input  wire logic                timer1_capture_event,
	input  wire logic                timer1_compare_a_event,
	input  wire logic                timer1_compare_b_event,
	input  wire logic                timer1_overflow_event,
	input  wire logic                timer0_overflow_event,
	input  wire logic                serial_transfer_done,
	input  wire logic                uart_rx_done,
	input  wire logic                uart_tx_buffer_empty,
	input  wire logic                uart_tx_done,
	input  wire logic                adc_done_event,
	input  wire logic                eeprom_ready_event,
	input  wire logic                comparator_event,
	input  wire logic                twi_event,
	input  wire logic                program_store_ready,
	input  wire logic                vec_ready,
	output logic                     vec_valid,
	output logic                     vec_is_reset,
	output logic      [ADDR_W-1:0]   vec_addr,
	output logic      [IDX_W-1:0]    vec_irq_index,
	output logic      [CTL_W-1:0]    general_irq_control_reg,
	output logic                     vector_select
);

	// ----------------------------------------------------------------
	// Request gathering
	// ----------------------------------------------------------------
	logic [NUM_IRQ-1:0] req_vec;
	logic [IDX_W-1:0]   win_idx;
	logic               win_any;

	// Bit order is the vector order, so encoder priority equals table order
	always_comb begin
		req_vec             = '0;
		req_vec[IRQ_EXT0]   = external_request_0;
		req_vec[IRQ_EXT1]   = external_request_1;
		req_vec[IRQ_T2CMP]  = timer2_compare_event;
		req_vec[IRQ_T2OVF]  = timer2_overflow_event;
		req_vec[IRQ_T1CAP]  = timer1_capture_event;
		req_vec[IRQ_T1CMPA] = timer1_compare_a_event;
		req_vec[IRQ_T1CMPB] = timer1_compare_b_event;
		req_vec[IRQ_T1OVF]  = timer1_overflow_event;
		req_vec[IRQ_T0OVF]  = timer0_overflow_event;
		req_vec[IRQ_SPI]    = serial_transfer_done;
		req_vec[IRQ_URX]    = uart_rx_done;
		req_vec[IRQ_UTXE]   = uart_tx_buffer_empty;
		req_vec[IRQ_UTX]    = uart_tx_done;
		req_vec[IRQ_ADC]    = adc_done_event;
		req_vec[IRQ_EE]     = eeprom_ready_event;
		req_vec[IRQ_ACMP]   = comparator_event;
		req_vec[IRQ_TWI]    = twi_event;
		req_vec[IRQ_STORE]  = program_store_ready;
	end

	rivm_prio_enc u_prio (
		.req         (req_vec),
		.idx         (win_idx),
		.any_pending (win_any)
	);

	// ----------------------------------------------------------------
	// Control register and fuse capture
	// ----------------------------------------------------------------
	logic [CTL_W-1:0]  irq_ctl_reg;
	logic [CTL_W-1:0]  irq_ctl_next;
	logic              fuse_reg;
	logic              fuse_next;
	logic              fuse_cap_reg;
	logic              fuse_cap_next;

	// Fuse is sampled once after reset release, never inside reset
	always_comb begin
		irq_ctl_next  = irq_ctl_reg;
		fuse_next     = fuse_reg;
		fuse_cap_next = fuse_cap_reg;
		if (irq_ctl_wr) begin
			irq_ctl_next = irq_ctl_wdata;
		end
		if (!fuse_cap_reg) begin
			fuse_next     = boot_reset_fuse;
			fuse_cap_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_ctl_reg  <= CTL_RST;
			fuse_reg     <= FUSE_UNPROG;
			fuse_cap_reg <= 1'b0;
		end else if (clk_en) begin
			irq_ctl_reg  <= irq_ctl_next;
			fuse_reg     <= fuse_next;
			fuse_cap_reg <= fuse_cap_next;
		end
	end

	assign general_irq_control_reg = irq_ctl_reg;
	assign vector_select           = irq_ctl_reg[VSEL_BIT];

	// ----------------------------------------------------------------
	// Address arithmetic
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] reset_target;
	logic [ADDR_W-1:0] table_start;
	logic [ADDR_W-1:0] irq_target;

	// Reset target ignores the select bit, which software may leave set
	always_comb begin
		if (fuse_reg == FUSE_UNPROG) begin
			reset_target = APP_RESET_ADDR;
		end else begin
			reset_target = boot_reset_addr;
		end
		if (vector_select) begin
			table_start = ADDR_W'(boot_reset_addr + APP_TABLE_START);
		end else begin
			table_start = APP_TABLE_START;
		end
		irq_target = ADDR_W'(table_start + ADDR_W'(win_idx) * VEC_STEP);
	end

	// ----------------------------------------------------------------
	// Dispatch sequencer
	// ----------------------------------------------------------------
	rivm_state_e       state_reg;
	rivm_state_e       state_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic [IDX_W-1:0]  idx_reg;
	logic [IDX_W-1:0]  idx_next;

	// Reset vector is offered first after every reset, then interrupts;
	// the winner is latched so a late higher request cannot tear the offer
	always_comb begin
		state_next = state_reg;
		addr_next  = addr_reg;
		idx_next   = idx_reg;
		unique case (state_reg)
			RIVM_ST_RESET: begin
				if (!fuse_cap_reg) begin
					addr_next = addr_reg;
				end else begin
					addr_next = reset_target;
					if (vec_ready && vec_valid) begin
						state_next = RIVM_ST_IDLE;
					end
				end
			end
			RIVM_ST_IDLE: begin
				if (win_any) begin
					addr_next  = irq_target;
					idx_next   = win_idx;
					state_next = RIVM_ST_IRQ;
				end
			end
			RIVM_ST_IRQ: begin
				if (vec_ready) begin
					state_next = RIVM_ST_IDLE;
				end
			end
			default: begin
				state_next = RIVM_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= RIVM_ST_RESET;
			addr_reg  <= APP_RESET_ADDR;
			idx_reg   <= IDX_ZERO;
		end else if (clk_en) begin
			state_reg <= state_next;
			addr_reg  <= addr_next;
			idx_reg   <= idx_next;
		end
	end

	// Valid in reset state only once the fuse-derived address is loaded
	logic reset_ready_reg;
	logic reset_ready_next;

	always_comb begin
		reset_ready_next = fuse_cap_reg && (state_reg == RIVM_ST_RESET);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reset_ready_reg <= 1'b0;
		end else if (clk_en) begin
			reset_ready_reg <= reset_ready_next;
		end
	end

	assign vec_valid     = (state_reg == RIVM_ST_IRQ) || ((state_reg == RIVM_ST_RESET) && reset_ready_reg);
	assign vec_is_reset  = (state_reg == RIVM_ST_RESET);
	assign vec_addr      = addr_reg;
	assign vec_irq_index = idx_reg;

endmodule // rivm_vector_map

// File: rivm_vector_map_checker.sv
// Purpose: Port-level assertions for the vector map
// Assumes: Select is written only while no request pends
// Notes:   Offered address is judged against the select in force
`timescale 1ns/1ps
module rivm_vector_map_checker
	import rivm_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              srst,
	input wire logic              clk_en,
	input wire logic              boot_reset_fuse,
	input wire logic [ADDR_W-1:0] boot_reset_addr,
	input wire logic              irq_ctl_wr,
	input wire logic [CTL_W-1:0]  irq_ctl_wdata,
	input wire logic              vec_ready,
	input wire logic              vec_valid,
	input wire logic              vec_is_reset,
	input wire logic [ADDR_W-1:0] vec_addr,
	input wire logic [IDX_W-1:0]  vec_irq_index,
	input wire logic [CTL_W-1:0]  general_irq_control_reg,
	input wire logic              vector_select
);
	// ----------------------------------------------------------------
	// Vector port and control register
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	sel_mirror_a: assert property (vector_select == general_irq_control_reg[VSEL_BIT])
		else $error("select bit differs from register");
	ctl_write_a: assert property (clk_en && irq_ctl_wr |=> general_irq_control_reg == $past(irq_ctl_wdata))
		else $error("register write lost");
	ctl_hold_a: assert property (!(clk_en && irq_ctl_wr) |=> $stable(general_irq_control_reg))
		else $error("register changed without write");
	// Frozen edges must leave the offer untouched
	freeze_hold_a: assert property (!clk_en |=> $stable(vec_addr) && $stable(vec_valid) && $stable(vec_irq_index))
		else $error("state moved while frozen");
	reset_addr_a: assert property (vec_valid && vec_is_reset |->
		vec_addr == (boot_reset_fuse ? APP_RESET_ADDR : boot_reset_addr))
		else $error("wrong reset target");
	irq_addr_a: assert property (vec_valid && !vec_is_reset |-> vec_addr ==
		(vector_select ? boot_reset_addr : 12'h000) + APP_TABLE_START + {7'h00, vec_irq_index})
		else $error("wrong interrupt vector");
	offer_hold_a: assert property (vec_valid && !vec_ready |=> vec_valid && $stable(vec_addr))
		else $error("offer dropped before accept");
	accept_drop_a: assert property (vec_valid && vec_ready && clk_en |=> !vec_valid)
		else $error("offer stayed after accept");
	reset_soon_a: assert property ($fell(srst) |-> ##[0:4] (vec_valid && vec_is_reset))
		else $error("reset vector not offered");
endmodule // rivm_vector_map_checker

bind rivm_vector_map rivm_vector_map_checker u_chk (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
	.boot_reset_fuse(boot_reset_fuse), .boot_reset_addr(boot_reset_addr), .irq_ctl_wr(irq_ctl_wr),
	.irq_ctl_wdata(irq_ctl_wdata), .vec_ready(vec_ready), .vec_valid(vec_valid), .vec_is_reset(vec_is_reset),
	.vec_addr(vec_addr), .vec_irq_index(vec_irq_index), .general_irq_control_reg(general_irq_control_reg),
	.vector_select(vector_select));

// File: rivm_core_model.sv
// Purpose: Fetch side of the core taking offered vectors
// Assumes: Same clock as the vector map
// Notes:   Ready lags an offer by one cycle, so stalls are natural
`timescale 1ns/1ps
module rivm_core_model
	import rivm_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic srst,
	input  wire logic stall,
	input  wire logic vec_valid,
	output logic      vec_ready
);
	logic ready_reg, ready_next;
	// Accept only a standing offer; stall holds the core busy
	always_comb ready_next = vec_valid && !stall;
	always_ff @(posedge clk_sys) begin
		ready_reg <= srst ? 1'b0 : ready_next;
	end
	assign vec_ready = ready_reg;
endmodule // rivm_core_model

// File: rivm_vector_map_bench.sv
// Purpose: Self-checking bench for the vector map
// Assumes: Core model accepts one cycle after an offer
// Notes:   Select changes only with no request pending
`timescale 1ns/1ps
module rivm_vector_map_bench
	import rivm_pkg::*;
;
	logic               clk_sys, srst, clk_en, fuse, irq_ctl_wr, stall, vec_ready, vec_valid, vec_is_reset, vsel;
	logic               rst_seen;
	logic [ADDR_W-1:0]  boot_addr, vec_addr, a;
	logic [IDX_W-1:0]   vec_irq_index, i;
	logic [CTL_W-1:0]   irq_ctl_wdata, irq_ctl_q;
	logic [NUM_IRQ-1:0] req;
	int                 err_total, samples_checked;

	rivm_vector_map dut (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .boot_reset_fuse(fuse),
		.boot_reset_addr(boot_addr), .irq_ctl_wr(irq_ctl_wr), .irq_ctl_wdata(irq_ctl_wdata),
		.external_request_0(req[0]),
		.external_request_1(req[1]), .timer2_compare_event(req[2]), .timer2_overflow_event(req[3]),
		.timer1_capture_event(req[4]), .timer1_compare_a_event(req[5]), .timer1_compare_b_event(req[6]),
		.timer1_overflow_event(req[7]), .timer0_overflow_event(req[8]), .serial_transfer_done(req[9]),
		.uart_rx_done(req[10]), .uart_tx_buffer_empty(req[11]), .uart_tx_done(req[12]), .adc_done_event(req[13]),
		.eeprom_ready_event(req[14]), .comparator_event(req[15]), .twi_event(req[16]),
		.program_store_ready(req[17]), .vec_ready(vec_ready), .vec_valid(vec_valid), .vec_is_reset(vec_is_reset),
		.vec_addr(vec_addr), .vec_irq_index(vec_irq_index), .general_irq_control_reg(irq_ctl_q),
		.vector_select(vsel));
	rivm_core_model core (.clk_sys(clk_sys), .srst(srst), .stall(stall), .vec_valid(vec_valid),
		.vec_ready(vec_ready));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	// Wait for an accept edge; the serviced requester drops its level there
	task automatic take();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!(vec_valid === 1'b1 && vec_ready === 1'b1) && n < 40);
		check(12'h000, (n >= 40) ? 12'hFFF : 12'h000);
		a = vec_addr;
		i = vec_irq_index;
		rst_seen = vec_is_reset;
		if (vec_is_reset === 1'b0) req[i] <= 1'b0;
	endtask
	task automatic do_reset(input logic f, input logic [ADDR_W-1:0] ba);
		srst <= 1'b1;
		fuse <= f;
		boot_addr <= ba;
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		check({4'h0, CTL_RST}, {4'h0, irq_ctl_q});
		take();
		check(f ? 12'h000 : ba, a);
		check(12'h001, {11'h000, rst_seen});
		$display("test reset fuse %0d done", f);
	endtask
	// Frozen edge must ignore the write, enabled edge must take it
	task automatic wr_ctl(input logic [CTL_W-1:0] d);
		@(posedge clk_sys);
		clk_en <= 1'b0;
		irq_ctl_wr <= 1'b1;
		irq_ctl_wdata <= ~d;
		@(posedge clk_sys);
		clk_en <= 1'b1;
		irq_ctl_wdata <= d;
		@(posedge clk_sys);
		irq_ctl_wr <= 1'b0;
		#1;
		check({4'h0, d}, {4'h0, irq_ctl_q});
		check({11'h000, d[1]}, {11'h000, vsel});
	endtask
	task automatic sweep(input logic [CTL_W-1:0] d, input logic [ADDR_W-1:0] base);
		wr_ctl(d);
		for (int k = 0; k < NUM_IRQ; k++) begin
			@(posedge clk_sys);
			req[k] <= 1'b1;
			take();
			check(base + 12'h001 + 12'(k), a);
			check(12'(k), {7'h00, i});
			check(12'h000, {11'h000, rst_seen});
		end
		$display("test sweep base %h done", base);
	endtask
	// Three at once, then a lower one arriving behind a stalled offer
	task automatic prio();
		@(posedge clk_sys);
		req <= 18'h21020;
		take();
		check(12'h005, {7'h00, i});
		take();
		check(12'h00C, {7'h00, i});
		take();
		check(12'h011, {7'h00, i});
		@(posedge clk_sys);
		stall <= 1'b1;
		req[9] <= 1'b1;
		repeat (4) @(posedge clk_sys);
		req[0] <= 1'b1;
		repeat (4) @(posedge clk_sys);
		stall <= 1'b0;
		take();
		check(12'h009, {7'h00, i});
		take();
		check(12'h000, {7'h00, i});
		$display("test priority done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		wrap_up();
	end
	initial begin
		{srst, clk_en, fuse, irq_ctl_wr, stall} = 5'b11100;
		boot_addr = 12'hC00;
		irq_ctl_wdata = 8'h00;
		req = '0;
		err_total = 0;
		samples_checked = 0;
		do_reset(1'b1, 12'hC00);
		sweep(8'h00, 12'h000);
		sweep(8'hFE, 12'hC00);
		do_reset(1'b0, 12'h800);
		sweep(8'h02, 12'h800);
		sweep(8'hFD, 12'h000);
		prio();
		wrap_up();
	end
endmodule // rivm_vector_map_bench
